// ### bcs_pkg.sv
// constants, field layouts and carrier types for the breaker command supervisor
// assumes a single 125 MHz clock and an APB register port with 32-bit data
package bcs_pkg;

   // ************************************************************
   // sizes and timing
   // ************************************************************
   localparam int BCS_NUM_BRK = 4;
   localparam int BCS_NUM_BOARD = 2;
   localparam int BCS_ID_WORDS = 5;
   localparam int BCS_CLK_NS = 8;
   localparam int BCS_TICK_NS = 1000000;
   localparam int BCS_TICK_CYCLES = (BCS_TICK_NS + BCS_CLK_NS - 1) / BCS_CLK_NS;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [11:0] BCS_ADDR_STATUS = 12'h000;
   localparam logic [11:0] BCS_ADDR_REMOTE = 12'h004;
   localparam logic [11:0] BCS_ADDR_EVT_STAT = 12'h008;
   localparam logic [11:0] BCS_ADDR_EVT_MASK = 12'h00c;
   localparam logic [11:0] BCS_ADDR_CFG_BASE = 12'h010;
   localparam logic [11:0] BCS_ADDR_ID_BASE = 12'h040;
   localparam int BCS_NUM_CFG = 8;

   // settings, in ms, index into the settings block
   localparam int BCS_CFG_TRANS = 0;
   localparam int BCS_CFG_OPEN_FAIL = 1;
   localparam int BCS_CFG_CLOSE_FAIL = 2;
   localparam int BCS_CFG_TRIP = 3;
   localparam int BCS_CFG_MIN_OPEN = 4;
   localparam int BCS_CFG_MAX_OPEN = 5;
   localparam int BCS_CFG_MIN_CLOSE = 6;
   localparam int BCS_CFG_MAX_CLOSE = 7;
   localparam logic [15:0] BCS_TRANS_MS_RST = 16'h0032;
   localparam logic [15:0] BCS_FAIL_MS_RST = 16'h0064;
   localparam logic [15:0] BCS_TRIP_MS_RST = 16'h00c8;
   localparam logic [15:0] BCS_MIN_CMD_MS_RST = 16'h0064;
   localparam logic [15:0] BCS_MAX_CMD_MS_RST = 16'h03e8;
   localparam logic [BCS_NUM_CFG-1:0][15:0] BCS_CFG_RST = {BCS_MAX_CMD_MS_RST, BCS_MIN_CMD_MS_RST,
      BCS_MAX_CMD_MS_RST, BCS_MIN_CMD_MS_RST, BCS_TRIP_MS_RST, BCS_FAIL_MS_RST, BCS_FAIL_MS_RST, BCS_TRANS_MS_RST};

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int BCS_STAT_STRIDE = 8;
   localparam int BCS_REM_CLOSE = 4;
   localparam int BCS_EVT_OPEN_FAIL = 0;
   localparam int BCS_EVT_CLOSE_FAIL = 4;
   localparam int BCS_EVT_INVALID = 8;
   localparam int BCS_EVT_CHANGE = 12;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {BCS_POS_MOVING, BCS_POS_OPEN, BCS_POS_CLOSED, BCS_POS_INVALID} bcs_pos_t;

   typedef struct packed {
      logic on;
      logic watch;
      logic fail;
      logic req_q;
      logic [15:0] t;
   } bcs_cmd_t;

   typedef struct packed {
      bcs_pos_t pos;
      logic [15:0] trans_t;
      bcs_cmd_t opn;
      bcs_cmd_t cls;
      logic trip;
      logic [15:0] trip_t;
   } bcs_brk_t;

endpackage : bcs_pkg

// ### bcs_supervisor.sv
// top of the breaker command supervisor: four breaker units, their timers and the APB register file
// assumes contact, request and block inputs synchronous to ref_clk; APB driven from the same clock
//
// Summary of operation
// - position comes from the closed and opened contacts, which must differ, and equal pairs are invalid.
// - equal contacts are tolerated while moving only until the transition maximum time runs out.
// - while the contacts sit in an invalid pair inside that window the reported position is held.
// - a command stays on while its request stays on and until the matching position arrives.
// - a command is stretched to its own minimum activation time even if the breaker has moved.
// - a command is dropped when its own maximum activation time runs out even if nothing moved.
// - a fail flag is raised when the position change does not follow a command within its failure time.
// - a rising fail flag starts a motor trip pulse of the set duration, 0.1 to 10 s, 200 ms by default.
// - a raised fail flag does not cut the command short.
// - while the block input is high no command is carried out on that breaker.
// - requests come from panel inputs and remote control, and the first breaker of a board also opens on isolation.
// - each breaker carries a readable 20-character text in its five identifier words from 0x040.
// - the transition maximum time is set in ms from 0 to 30 s, 50 ms by default.
// - the open and close failure times are set in ms from 0.1 to 30 s, 100 ms by default.
// - four independent breaker units, two to each analog board.
`timescale 1ns/10ps
`default_nettype none

module bcs_supervisor
   import bcs_pkg::*;
#(
   parameter int TICK_CYCLES = BCS_TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [BCS_NUM_BRK-1:0] position_closed_in,
   input wire logic [BCS_NUM_BRK-1:0] position_opened_in,
   input wire logic [BCS_NUM_BRK-1:0] breaker_block_in,
   input wire logic [BCS_NUM_BRK-1:0] panel_open_request,
   input wire logic [BCS_NUM_BRK-1:0] panel_close_request,
   input wire logic [BCS_NUM_BOARD-1:0] isolation_open_request,
   output logic [BCS_NUM_BRK-1:0] open_cmd_out,
   output logic [BCS_NUM_BRK-1:0] close_cmd_out,
   output logic [BCS_NUM_BRK-1:0] open_fail_flag,
   output logic [BCS_NUM_BRK-1:0] close_fail_flag,
   output logic [BCS_NUM_BRK-1:0] motor_trip_out,
   output logic irq
);

   // ************************************************************
   // register map, one aligned 32-bit word each
   // ************************************************************
   // 0x000 status, read only, one byte per breaker: {block, trip, close fail, open fail, close cmd, open cmd, pos}
   //       pos 0 moving or unknown, 1 open, 2 closed, 3 invalid
   // 0x004 remote requests as levels, [3:0] open and [7:4] close; software must drop them again
   // 0x008 events, write one to clear: [3:0] open fail, [7:4] close fail, [11:8] invalid pair, [15:12] settled
   // 0x00c event mask, same layout; irq stands while an unmasked event is pending
   // 0x010 to 0x02c settings in ms, low 16 bits: transition, open fail, close fail, trip,
   //       min open, max open, min close, max close
   // 0x040 to 0x08c identifier text, breaker b word w at 0x040 + (5b + w) * 4
   // any other offset answers with pslverr and is not written; writes to status are dropped
   // settings are not clamped, so software must keep them within their allowed ranges

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [16:0] tick_cnt;
      logic tick;
      bcs_brk_t [BCS_NUM_BRK-1:0] brk;
      logic [7:0] remote;
      logic [15:0] evt;
      logic [15:0] mask;
      logic [BCS_NUM_CFG-1:0][15:0] cfg;
      logic [BCS_NUM_BRK*BCS_ID_WORDS-1:0][31:0] ident;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
   } bcs_state_t;

   localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
   localparam logic [11:0] ID_END = 12'(BCS_ADDR_ID_BASE + 12'(BCS_NUM_BRK * BCS_ID_WORDS * 4));
   localparam logic [11:0] CFG_END = 12'(BCS_ADDR_CFG_BASE + 12'(BCS_NUM_CFG * 4));

   bcs_state_t st_r;
   bcs_state_t st_nxt;
   logic [1:0] rst_sync_r;
   logic rst_sync_n;

   // ************************************************************
   // reset release
   // ************************************************************
   // assertion is immediate, release is retimed so every state bit leaves reset on the same edge;
   // the price is two extra cycles of reset after rst_n rises
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_sync_r[1];

   // ************************************************************
   // command timer step, shared by open and close of every breaker
   // ************************************************************
   function automatic bcs_cmd_t cmd_step(
      input bcs_cmd_t c,
      input logic req,
      input logic blk,
      input logic reached,
      input logic tick,
      input logic [15:0] tmin,
      input logic [15:0] tmax,
      input logic [15:0] tfail
   );
      bcs_cmd_t n;
      n = c;
      n.req_q = req;
      if (blk) begin
         // a held request is not replayed when the block lifts; it must be raised again
         // the fail watch stops too, so a blocked breaker never raises a new fail
         n.on = 1'b0;
         n.watch = 1'b0;
      end else if (req && !c.req_q && !c.on) begin
         n.on = 1'b1;
         n.watch = 1'b1;
         n.fail = 1'b0;
         n.t = 16'h0000;
      end else begin
         if (tick && (c.on || c.watch) && c.t != 16'hffff) begin
            n.t = c.t + 16'h0001;
         end
         if (c.on && c.t >= tmin && (!req || reached)) begin
            n.on = 1'b0;
         end
         if (c.on && c.t >= tmax) begin
            n.on = 1'b0;
         end
         if (c.watch && reached) begin
            n.watch = 1'b0;
         end else if (c.watch && c.t >= tfail) begin
            // the command itself is left alone here
            n.watch = 1'b0;
            n.fail = 1'b1;
         end
      end
      return n;
   endfunction : cmd_step

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic [31:0] rd;
      logic hit;
      logic wr;
      logic [4:0] idx;
      logic [2:0] cidx;
      logic [15:0] evt_set;
      logic [15:0] evt_clr;
      logic valid;
      logic req_o;
      logic req_c;
      logic fail_rise;
      logic open_rise;
      logic close_rise;
      bcs_pos_t pos_n;
      rd = 32'h0000_0000;
      hit = 1'b0;
      wr = 1'b0;
      idx = 5'h00;
      cidx = 3'h0;
      evt_set = 16'h0000;
      evt_clr = 16'h0000;
      valid = 1'b0;
      req_o = 1'b0;
      req_c = 1'b0;
      fail_rise = 1'b0;
      open_rise = 1'b0;
      close_rise = 1'b0;
      pos_n = BCS_POS_MOVING;
      st_nxt = st_r;

      // one common millisecond tick
      // timers count whole ticks, so a setting is kept to within one tick plus a cycle;
      // one shared prescaler costs far less than a fine counter per timer
      st_nxt.tick = 1'b0;
      if (st_r.tick_cnt >= TICK_LAST) begin
         st_nxt.tick_cnt = 17'h00000;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.tick_cnt = st_r.tick_cnt + 17'h00001;
      end

      for (int b = 0; b < BCS_NUM_BRK; b++) begin
         // position
         // an equal pair ages in the same window whether or not a command is running
         valid = position_closed_in[b] ^ position_opened_in[b];
         pos_n = st_r.brk[b].pos;
         if (valid) begin
            pos_n = position_closed_in[b] ? BCS_POS_CLOSED : BCS_POS_OPEN;
            st_nxt.brk[b].trans_t = 16'h0000;
         end else if (st_r.brk[b].trans_t >= st_r.cfg[BCS_CFG_TRANS]) begin
            pos_n = BCS_POS_INVALID;
         end else if (st_r.tick) begin
            // held position while still inside the window
            st_nxt.brk[b].trans_t = st_r.brk[b].trans_t + 16'h0001;
         end
         st_nxt.brk[b].pos = pos_n;
         if (pos_n != st_r.brk[b].pos) begin
            if (pos_n == BCS_POS_INVALID) begin
               evt_set[BCS_EVT_INVALID + b] = 1'b1;
            end else begin
               evt_set[BCS_EVT_CHANGE + b] = 1'b1;
            end
         end

         // request sources; isolation opens only the first breaker of each board
         req_o = panel_open_request[b] | st_r.remote[b];
         if ((b % 2) == 0) begin
            req_o = req_o | isolation_open_request[b / 2];
         end
         req_c = panel_close_request[b] | st_r.remote[BCS_REM_CLOSE + b];

         st_nxt.brk[b].opn = cmd_step(
            st_r.brk[b].opn,
            req_o,
            breaker_block_in[b],
            pos_n == BCS_POS_OPEN,
            st_r.tick,
            st_r.cfg[BCS_CFG_MIN_OPEN],
            st_r.cfg[BCS_CFG_MAX_OPEN],
            st_r.cfg[BCS_CFG_OPEN_FAIL]
         );
         st_nxt.brk[b].cls = cmd_step(
            st_r.brk[b].cls,
            req_c,
            breaker_block_in[b],
            pos_n == BCS_POS_CLOSED,
            st_r.tick,
            st_r.cfg[BCS_CFG_MIN_CLOSE],
            st_r.cfg[BCS_CFG_MAX_CLOSE],
            st_r.cfg[BCS_CFG_CLOSE_FAIL]
         );
         open_rise = st_nxt.brk[b].opn.fail && !st_r.brk[b].opn.fail;
         close_rise = st_nxt.brk[b].cls.fail && !st_r.brk[b].cls.fail;
         if (open_rise) begin
            evt_set[BCS_EVT_OPEN_FAIL + b] = 1'b1;
         end
         if (close_rise) begin
            evt_set[BCS_EVT_CLOSE_FAIL + b] = 1'b1;
         end

         // motor protection trip
         // a second fail while the pulse runs starts it again from zero
         fail_rise = open_rise || close_rise;
         if (fail_rise) begin
            st_nxt.brk[b].trip = 1'b1;
            st_nxt.brk[b].trip_t = 16'h0000;
         end else if (st_r.brk[b].trip) begin
            if (st_r.brk[b].trip_t >= st_r.cfg[BCS_CFG_TRIP]) begin
               st_nxt.brk[b].trip = 1'b0;
            end else if (st_r.tick) begin
               st_nxt.brk[b].trip_t = st_r.brk[b].trip_t + 16'h0001;
            end
         end
      end

      // ************************************************************
      // register read mux and decode
      // ************************************************************
      // a misaligned or out-of-range offset is unmapped and answers with pslverr
      if (paddr == BCS_ADDR_STATUS) begin
         hit = 1'b1;
         for (int b = 0; b < BCS_NUM_BRK; b++) begin
            rd[b*BCS_STAT_STRIDE +: BCS_STAT_STRIDE] = {
               breaker_block_in[b],
               st_r.brk[b].trip,
               st_r.brk[b].cls.fail,
               st_r.brk[b].opn.fail,
               st_r.brk[b].cls.on,
               st_r.brk[b].opn.on,
               st_r.brk[b].pos
            };
         end
      end else if (paddr == BCS_ADDR_REMOTE) begin
         hit = 1'b1;
         rd = {24'h000000, st_r.remote};
      end else if (paddr == BCS_ADDR_EVT_STAT) begin
         hit = 1'b1;
         rd = {16'h0000, st_r.evt};
      end else if (paddr == BCS_ADDR_EVT_MASK) begin
         hit = 1'b1;
         rd = {16'h0000, st_r.mask};
      end else if (paddr >= BCS_ADDR_CFG_BASE && paddr < CFG_END && paddr[1:0] == 2'h0) begin
         hit = 1'b1;
         cidx = 3'(12'(paddr - BCS_ADDR_CFG_BASE) >> 2);
         rd = {16'h0000, st_r.cfg[cidx]};
      end else if (paddr >= BCS_ADDR_ID_BASE && paddr < ID_END && paddr[1:0] == 2'h0) begin
         hit = 1'b1;
         idx = 5'(12'(paddr - BCS_ADDR_ID_BASE) >> 2);
         rd = st_r.ident[idx];
      end

      // one wait state: pready rises in the second access cycle
      // a write lands only at the edge where the master sees pready, never earlier
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      if (psel && penable && !st_r.pready) begin
         st_nxt.pready = 1'b1;
         st_nxt.pslverr = !hit;
         st_nxt.prdata = (hit && !pwrite) ? rd : 32'h0000_0000;
      end
      wr = psel && penable && st_r.pready && pwrite && hit;
      if (wr) begin
         if (paddr == BCS_ADDR_REMOTE) begin
            // a level left here keeps requesting until software clears it
            st_nxt.remote = pwdata[7:0];
         end else if (paddr == BCS_ADDR_EVT_STAT) begin
            evt_clr = pwdata[15:0];
         end else if (paddr == BCS_ADDR_EVT_MASK) begin
            st_nxt.mask = pwdata[15:0];
         end else if (paddr >= BCS_ADDR_ID_BASE) begin
            st_nxt.ident[idx] = pwdata;
         end else if (paddr >= BCS_ADDR_CFG_BASE) begin
            st_nxt.cfg[cidx] = pwdata[15:0];
         end
      end

      // a new event beats a clear in the same cycle
      st_nxt.evt = (st_r.evt & ~evt_clr) | evt_set;
      st_nxt.irq = |(st_nxt.evt & st_nxt.mask);
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_r <= '0;
         st_r.cfg <= BCS_CFG_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // outputs, wiring only
   // ************************************************************
   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign irq = st_r.irq;
   always_comb begin
      for (int b = 0; b < BCS_NUM_BRK; b++) begin
         open_cmd_out[b] = st_r.brk[b].opn.on;
         close_cmd_out[b] = st_r.brk[b].cls.on;
         open_fail_flag[b] = st_r.brk[b].opn.fail;
         close_fail_flag[b] = st_r.brk[b].cls.fail;
         motor_trip_out[b] = st_r.brk[b].trip;
      end
   end

endmodule : bcs_supervisor

`default_nettype wire

// ### bcs_supervisor_monitor.sv
// concurrent checks on the supervisor's APB handshake and breaker outputs
// assumes the bench keeps MAX above FAIL and does not block a breaker mid-command
`timescale 1ns/10ps
`default_nettype none
module bcs_supervisor_monitor
   import bcs_pkg::*;
#(
   parameter int TICK_CYCLES = BCS_TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [BCS_NUM_BRK-1:0] breaker_block_in,
   input wire logic [BCS_NUM_BRK-1:0] open_cmd_out,
   input wire logic [BCS_NUM_BRK-1:0] close_cmd_out,
   input wire logic [BCS_NUM_BRK-1:0] close_fail_flag,
   input wire logic [BCS_NUM_BRK-1:0] open_fail_flag,
   input wire logic [BCS_NUM_BRK-1:0] motor_trip_out
);
   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_one_wait_state: assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("wait state wrong");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_block_no_start: assert property (
      (((open_cmd_out & ~$past(open_cmd_out)) | (close_cmd_out & ~$past(close_cmd_out)))
      & $past(breaker_block_in)) == '0) else $error("command started while blocked");
   a_trip_on_fail: assert property (
      (((open_fail_flag & ~$past(open_fail_flag)) | (close_fail_flag & ~$past(close_fail_flag)))
      & ~motor_trip_out) == '0) else $error("fail without trip");
   a_fail_keeps_cmd: assert property (
      $rose(close_fail_flag[1]) && !breaker_block_in[1] |-> close_cmd_out[1] [*8])
      else $error("fail cut the command");
   a_cmd_min_width: assert property (
      $rose(open_cmd_out[0]) && !breaker_block_in[0] |-> open_cmd_out[0] [*8])
      else $error("command too short");
   a_trip_min_width: assert property (
      $rose(motor_trip_out[1]) |-> motor_trip_out[1] [*8])
      else $error("trip pulse too short");
   c_open: cover property ($rose(open_cmd_out[0]));
   c_fail: cover property ($rose(close_fail_flag[1]));
   c_err: cover property (pslverr);
endmodule : bcs_supervisor_monitor
bind bcs_supervisor bcs_supervisor_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (.ref_clk(ref_clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .breaker_block_in(breaker_block_in),
   .open_cmd_out(open_cmd_out), .close_cmd_out(close_cmd_out), .close_fail_flag(close_fail_flag),
   .open_fail_flag(open_fail_flag), .motor_trip_out(motor_trip_out));
`default_nettype wire

// ### bcs_breaker_model.sv
// behavioural breakers: auxiliary contacts that follow the coil commands
// assumes commands synchronous to ref_clk; stuck and both_hi come from the bench
`timescale 1ns/10ps
`default_nettype none
module bcs_breaker_model
   import bcs_pkg::*;
#(
   parameter int MOVE_CYCLES = 20
) (
   input wire logic ref_clk,
   input wire logic [BCS_NUM_BRK-1:0] open_cmd_out,
   input wire logic [BCS_NUM_BRK-1:0] close_cmd_out,
   input wire logic [BCS_NUM_BRK-1:0] stuck,
   input wire logic [BCS_NUM_BRK-1:0] both_hi,
   output logic [BCS_NUM_BRK-1:0] position_closed_in,
   output logic [BCS_NUM_BRK-1:0] position_opened_in
);
   // ************************************************************
   // mechanism
   // ************************************************************
   // breakers 0 and 2 start closed, 1 and 3 open
   logic [BCS_NUM_BRK-1:0] closed_r = 4'h5;
   int mv [BCS_NUM_BRK] = '{default: 0};
   always_ff @(posedge ref_clk) begin
      for (int b = 0; b < BCS_NUM_BRK; b++) begin
         if (mv[b] != 0) mv[b] <= mv[b] - 1;
         if (mv[b] == 1) closed_r[b] <= ~closed_r[b];
         if (mv[b] == 0 && !stuck[b] && ((open_cmd_out[b] && closed_r[b]) || (close_cmd_out[b] && !closed_r[b])))
            mv[b] <= MOVE_CYCLES;
      end
   end
   // both contacts open while travelling, as a real mechanism does
   always_comb begin
      for (int b = 0; b < BCS_NUM_BRK; b++) begin
         position_closed_in[b] = both_hi[b] || (mv[b] == 0 && closed_r[b]);
         position_opened_in[b] = both_hi[b] || (mv[b] == 0 && !closed_r[b]);
      end
   end
endmodule : bcs_breaker_model
`default_nettype wire

// ### tb.sv
// self-checking bench: APB master tasks and breaker scenarios against the supervisor
// assumes a 1 ms tick of 10 cycles, so every ms setting is ten clock cycles
`timescale 1ns/10ps
`default_nettype none
module tb
   import bcs_pkg::*;
;
   logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, e;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic [3:0] cl, op, blk = '0, p_op = '0, p_cl = '0, stuck = '0, bhi = '0, oc, cc, of, cf, mt;
   logic [1:0] iso = '0;
   int n_fail = 0, total_checks = 0;
   always #4 ref_clk = ~ref_clk;
   bcs_supervisor #(.TICK_CYCLES(10)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .position_closed_in(cl), .position_opened_in(op), .breaker_block_in(blk), .panel_open_request(p_op),
      .panel_close_request(p_cl), .isolation_open_request(iso), .open_cmd_out(oc), .close_cmd_out(cc),
      .open_fail_flag(of), .close_fail_flag(cf), .motor_trip_out(mt), .irq(irq));
   bcs_breaker_model i_brk (.ref_clk(ref_clk), .open_cmd_out(oc), .close_cmd_out(cc), .stuck(stuck),
      .both_hi(bhi), .position_closed_in(cl), .position_opened_in(op));
   // ************************************************************
   // tasks
   // ************************************************************
   task wrap_up;
      if (n_fail == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         n_fail++;
         wrap_up();
      end
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(0, a, '0);
      chk(q, exp);
   endtask : rd_chk
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc
   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      cyc(12);
      rst_n <= 1;
      cyc(6);
      for (int i = 0; i < BCS_NUM_CFG; i++) begin
         rd_chk(BCS_ADDR_CFG_BASE + 12'(4 * i), 32'(BCS_CFG_RST[i]));
      end
      apb(0, 12'hffc, '0);
      chk(e, 1'b1);
      apb(1, BCS_ADDR_CFG_BASE, 32'h5);
      rd_chk(BCS_ADDR_CFG_BASE, 32'h5);
      apb(1, BCS_ADDR_ID_BASE + 12'h014, 32'h41424344);
      rd_chk(BCS_ADDR_ID_BASE + 12'h014, 32'h41424344);
      rd_chk(BCS_ADDR_STATUS, 32'h01020102);
      apb(1, BCS_ADDR_EVT_STAT, 32'hffff);
      apb(1, BCS_ADDR_EVT_MASK, 32'hffff);
      // short panel pulse: the command must outlive it and the fast breaker
      p_op[0] <= 1;
      cyc(1);
      p_op[0] <= 0;
      cyc(3);
      chk(oc[0], 1'b1);
      cyc(500);
      chk(oc[0], 1'b1);
      cyc(600);
      chk(oc[0], 1'b0);
      chk(of[0], 1'b0);
      rd_chk(BCS_ADDR_EVT_STAT, 32'h1000);
      apb(1, BCS_ADDR_EVT_STAT, 32'h1000);
      // jammed breaker with the request held on
      stuck[1] <= 1;
      p_cl[1] <= 1;
      cyc(900);
      chk(cf[1], 1'b0);
      cyc(200);
      chk(cf[1], 1'b1);
      chk(cc[1], 1'b1);
      chk(mt[1], 1'b1);
      chk(irq, 1'b1);
      rd_chk(BCS_ADDR_EVT_STAT, 32'h0020);
      apb(1, BCS_ADDR_EVT_STAT, 32'h0020);
      cyc(2);
      chk(irq, 1'b0);
      cyc(2100);
      chk(mt[1], 1'b0);
      cyc(6500);
      chk(cc[1], 1'b1);
      cyc(500);
      chk(cc[1], 1'b0);
      p_cl[1] <= 0;
      blk[2] <= 1;
      p_op[2] <= 1;
      cyc(20);
      chk(oc[2], 1'b0);
      blk[2] <= 0;
      p_op[2] <= 0;
      cyc(2);
      iso[1] <= 1;
      cyc(4);
      chk(oc[2], 1'b1);
      iso[1] <= 0;
      // remote close of breaker 3 and remote open of the already open breaker 1
      apb(1, BCS_ADDR_REMOTE, 32'h82);
      cyc(3);
      chk(cc[3], 1'b1);
      chk(oc[1], 1'b1);
      apb(1, BCS_ADDR_REMOTE, 32'h0);
      // both contacts high on an open breaker: held, then invalid after 5 ms
      bhi[1] <= 1;
      cyc(30);
      apb(0, BCS_ADDR_STATUS, '0);
      chk((q >> 8) & 32'h3, 32'h1);
      cyc(40);
      apb(0, BCS_ADDR_STATUS, '0);
      chk((q >> 8) & 32'h3, 32'h3);
      apb(0, BCS_ADDR_EVT_STAT, '0);
      chk(q & 32'h200, 32'h200);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
